// file: lpddr_pin_pkg.sv
// Purpose: shared constants and carriers for the low-power ddr pin interface
// Assumes: link clock sampled by i_ref_clk, slow enough for edge detection
// Notes: command codes follow the usual sdram truth table
package lpddr_pin_pkg;
    localparam int DATA_W = 16;
    localparam int LANES = DATA_W / 8;
    localparam int ADDR_W = 14;
    localparam int BANKS = 4;
    localparam int AP_BIT = 10;
    localparam int ROW_W = 14;
    localparam int MODE_REGS = 4;

    // {ras_n, cas_n, we_n}
    localparam logic [2:0] CMD_LMR = 3'h0;
    localparam logic [2:0] CMD_REF = 3'h1;
    localparam logic [2:0] CMD_PRE = 3'h2;
    localparam logic [2:0] CMD_ACT = 3'h3;
    localparam logic [2:0] CMD_WR = 3'h4;
    localparam logic [2:0] CMD_RD = 3'h5;
    localparam logic [2:0] CMD_BST = 3'h6;
    localparam logic [2:0] CMD_NOP = 3'h7;

    localparam logic [1:0] RD_LAT = 2'h2;

    typedef struct packed {
        logic command_select_die0_n;
        logic ras_n;
        logic cas_n;
        logic we_n;
        logic bank_select_1;
        logic bank_select_0;
        logic [ADDR_W-1:0] addr;
    } cmd_bus_t;

    typedef struct packed {
        logic [DATA_W-1:0] data;
        logic [LANES-1:0] write_byte_mask;
    } beat_t;

    typedef enum logic [1:0] {
        PWR_ACTIVE = 2'h0,
        PWR_PRE_PD = 2'h1,
        PWR_ACT_PD = 2'h3,
        PWR_SELF_REF = 2'h2
    } pwr_state_t;
endpackage : lpddr_pin_pkg

// file: beat_buffer.sv
// Purpose: two-entry valid/ready buffer for write beats
// Assumes: single clock, synchronous reset
// Notes: full and empty are exact
module beat_buffer
    import lpddr_pin_pkg::*;
#(
    parameter int W = 18
) (
    input wire logic i_ref_clk,
    input wire logic i_srst,
    input wire logic i_valid,
    output logic o_ready,
    input wire logic [W-1:0] i_data,
    output logic o_valid,
    input wire logic i_ready,
    output logic [W-1:0] o_data
);
    typedef struct packed {
        logic [1:0][W-1:0] mem;
        logic rd_ptr;
        logic wr_ptr;
        logic [1:0] count;
    } buf_state_t;

    buf_state_t st_ff;
    buf_state_t nxt_st;
    logic push;
    logic pop;

    assign o_ready = (st_ff.count != 2'h2);
    assign o_valid = (st_ff.count != 2'h0);
    assign o_data = st_ff.mem[st_ff.rd_ptr];
    assign push = i_valid && o_ready;
    assign pop = o_valid && i_ready;

    always_comb begin
        nxt_st = st_ff;
        if (push) begin
            nxt_st.mem[st_ff.wr_ptr] = i_data;
            nxt_st.wr_ptr = ~st_ff.wr_ptr;
        end
        if (pop) begin
            nxt_st.rd_ptr = ~st_ff.rd_ptr;
        end
        if (push && !pop) begin
            nxt_st.count = st_ff.count + 2'h1;
        end else if (pop && !push) begin
            nxt_st.count = st_ff.count - 2'h1;
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_srst) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    property p_stall_holds;
        @(posedge i_ref_clk) disable iff (i_srst)
        (o_valid && !i_ready) |=> (o_valid && o_data == $past(o_data));
    endproperty
    a_stall_holds: assert property (p_stall_holds) else $error("stalled word lost"); // R9
endmodule : beat_buffer

// file: lpddr_pin_device.sv
// Purpose: device-side pin interface of a four-bank low-power ddr memory
// Assumes: link clock and pins sampled by i_ref_clk through two flops
// Notes: read edges from sampled link clock, write beats from sampled strobe; burst of two
//
// Notes on behaviour
// [R1] capture command inputs at link clock rise
// [R2] data moves on both link clock edges
// [R3] power gate high runs clocks and drivers
// [R4] gate low enters power-down by bank state
// [R5] gate sampled except asynchronous self refresh exit
// [R6] inputs ignored during power-down and self refresh
// [R7] select high masks the command
// [R8] command coded by select and strobes
// [R9] masked write bytes are discarded
// [R10] bank selects choose the target bank
// [R11] bank selects choose the mode register
// [R12] address carries row, column, auto precharge
// [R13] precharge one bank or all banks
// [R14] mode op-code taken from address inputs
// [R15] read strobe edge-aligned, write strobe centered
// [R16] overtemp flag follows temperature threshold
// [R17] data width sixteen, strobe per byte
// [R18] second die inputs unused on single die
// [R19] usual sdram command truth table
module lpddr_pin_device
    import lpddr_pin_pkg::*;
#(
    parameter int DW = DATA_W,
    parameter int AW = ADDR_W
) (
    input wire logic i_ref_clk,
    input wire logic i_srst,
    input wire logic i_link_clk,
    input wire logic i_power_gate_die0,
    input wire logic i_power_gate_die1,
    input wire logic i_command_select_die0_n,
    input wire logic i_command_select_die1_n,
    input wire logic i_ras_n,
    input wire logic i_cas_n,
    input wire logic i_we_n,
    input wire logic i_bank_select_0,
    input wire logic i_bank_select_1,
    input wire logic [AW-1:0] i_addr,
    input wire logic [LANES-1:0] i_write_byte_mask,
    input wire logic [DW-1:0] i_dq,
    output logic [DW-1:0] o_dq,
    output logic o_dq_oe,
    input wire logic [LANES-1:0] i_byte_strobe,
    output logic [LANES-1:0] o_byte_strobe,
    output logic o_byte_strobe_oe,
    input wire logic i_over_threshold,
    output logic o_overtemp_flag,
    output logic [BANKS-1:0] o_bank_open,
    output logic [1:0] o_power_state,
    output logic o_wr_valid,
    input wire logic i_wr_ready,
    output logic [DW-1:0] o_wr_data,
    output logic [LANES-1:0] o_wr_keep,
    output logic [1:0] o_wr_bank,
    output logic [AW-1:0] o_wr_col,
    input wire logic [DW-1:0] i_rd_data,
    output logic [1:0] o_rd_bank,
    output logic [AW-1:0] o_rd_col,
    output logic o_rd_req,
    output logic [AW-1:0] o_mode_reg0,
    output logic [AW-1:0] o_mode_reg1,
    output logic o_cmd_ignored
);
    localparam int SW = 6 + AW + LANES + DW + LANES + 1 + 1;
    localparam int BW = DW + LANES;

    typedef struct packed {
        logic [1:0][SW-1:0] sync;
        logic link_q;
        logic dqs_q;
        logic [BANKS-1:0] open;
        logic [BANKS-1:0][ROW_W-1:0] row;
        logic [MODE_REGS-1:0][AW-1:0] mode;
        pwr_state_t pwr;
        logic wr_pend;
        logic wr_half;
        logic [1:0] wr_bank;
        logic [AW-1:0] wr_col;
        logic [DW-1:0] wr_data;
        logic [LANES-1:0] wr_keep;
        logic [1:0] rd_cnt;
        logic rd_drive;
        logic rd_half;
        logic [1:0] rd_bank;
        logic [AW-1:0] rd_col;
        logic [DW-1:0] dq_out;
        logic [LANES-1:0] dqs_out;
        logic ignored;
        logic ot;
        logic [1:0] ot_sync;
        logic push;
    } dev_state_t;

    dev_state_t st_ff;
    dev_state_t nxt_st;

    logic [SW-1:0] raw;
    logic [SW-1:0] smp;
    logic s_cs_n, s_ras_n, s_cas_n, s_we_n, s_link, s_gate;
    logic [1:0] s_ba;
    logic [AW-1:0] s_addr;
    logic [LANES-1:0] s_dm;
    logic [DW-1:0] s_dq;
    logic [LANES-1:0] s_dqs;
    logic rise, fall, awake, strobe_edge;
    logic [2:0] cmd;
    logic buf_ready;
    logic [BW-1:0] buf_out;

    function automatic logic [BANKS-1:0] bank_onehot(input logic [1:0] ba);
        bank_onehot = '0;
        bank_onehot[ba] = 1'b1;
    endfunction : bank_onehot

    // second die select and gate are reserved on this single die part
    assign raw = {i_command_select_die0_n, i_ras_n, i_cas_n, i_we_n, // R18
                  i_bank_select_1, i_bank_select_0, i_addr, i_write_byte_mask, i_dq,
                  i_byte_strobe, i_link_clk, i_power_gate_die0};
    assign smp = st_ff.sync[1];
    assign {s_cs_n, s_ras_n, s_cas_n, s_we_n, s_ba, s_addr, s_dm, s_dq, s_dqs,
            s_link, s_gate} = smp;

    assign rise = s_link && !st_ff.link_q; // R1
    assign fall = !s_link && st_ff.link_q;
    // lane 0 strobe times the beat for both byte lanes
    assign strobe_edge = (s_dqs[0] != st_ff.dqs_q); // R15
    assign awake = (st_ff.pwr == PWR_ACTIVE); // R3
    assign cmd = {s_ras_n, s_cas_n, s_we_n}; // R8 R19

    always_comb begin
        nxt_st = st_ff;
        nxt_st.sync[0] = raw;
        nxt_st.sync[1] = st_ff.sync[0];
        nxt_st.link_q = s_link;
        nxt_st.dqs_q = s_dqs[0];
        nxt_st.ot_sync = {st_ff.ot_sync[0], i_over_threshold};
        nxt_st.ot = st_ff.ot_sync[1]; // R16
        nxt_st.ignored = 1'b0;
        nxt_st.push = 1'b0;
        // self refresh exit acts on the gate level without waiting for an edge
        if (st_ff.pwr == PWR_SELF_REF && s_gate) begin
            nxt_st.pwr = PWR_ACTIVE; // R5
        end else if (rise) begin
            case (st_ff.pwr)
                PWR_ACTIVE: begin
                    if (!s_gate) begin
                        if (st_ff.open != '0) begin
                            nxt_st.pwr = PWR_ACT_PD; // R4
                        end else if (!s_cs_n && cmd == CMD_REF) begin
                            nxt_st.pwr = PWR_SELF_REF; // R4
                        end else begin
                            nxt_st.pwr = PWR_PRE_PD; // R4
                        end
                    end else if (s_cs_n) begin
                        nxt_st.ignored = 1'b1; // R7
                    end else begin
                        case (cmd)
                            CMD_ACT: begin
                                nxt_st.open[s_ba] = 1'b1; // R10
                                nxt_st.row[s_ba] = s_addr; // R12
                            end
                            CMD_PRE: begin
                                if (s_addr[AP_BIT]) begin
                                    nxt_st.open = '0; // R13
                                end else begin
                                    nxt_st.open = st_ff.open & ~bank_onehot(s_ba); // R13
                                end
                            end
                            CMD_LMR: begin
                                nxt_st.mode[s_ba] = s_addr; // R11 R14
                            end
                            CMD_WR: begin
                                nxt_st.wr_pend = 1'b1;
                                nxt_st.wr_half = 1'b0;
                                nxt_st.wr_bank = s_ba;
                                nxt_st.wr_col = s_addr; // R12
                            end
                            CMD_RD: begin
                                nxt_st.rd_cnt = RD_LAT;
                                nxt_st.rd_bank = s_ba;
                                nxt_st.rd_col = s_addr; // R12
                            end
                            default: begin
                            end
                        endcase
                        if ((cmd == CMD_WR || cmd == CMD_RD) && s_addr[AP_BIT]) begin
                            nxt_st.open = st_ff.open & ~bank_onehot(s_ba); // R12
                        end
                    end
                end
                PWR_PRE_PD, PWR_ACT_PD: begin
                    if (s_gate) begin
                        nxt_st.pwr = PWR_ACTIVE; // R5
                    end
                end
                default: begin
                end
            endcase
        end
        // write beats captured on write strobe edges, one per edge
        if (st_ff.wr_pend && awake && strobe_edge && !st_ff.push) begin // R2 R15 R6
            if (!st_ff.wr_half) begin
                nxt_st.wr_data = s_dq;
                nxt_st.wr_keep = ~s_dm; // R9
                nxt_st.wr_half = 1'b1;
                nxt_st.push = 1'b1;
            end else begin
                nxt_st.wr_data = s_dq;
                nxt_st.wr_keep = ~s_dm; // R9
                nxt_st.wr_pend = 1'b0;
                nxt_st.push = 1'b1;
            end
        end
        // read: drive strobe edge aligned with data on both edges
        if (rise && st_ff.rd_cnt != 2'h0 && awake) begin
            nxt_st.rd_cnt = st_ff.rd_cnt - 2'h1;
            if (st_ff.rd_cnt == 2'h1) begin
                nxt_st.rd_drive = 1'b1;
                nxt_st.rd_half = 1'b0;
                nxt_st.dq_out = i_rd_data;
                nxt_st.dqs_out = '1; // R15
            end
        end else if (st_ff.rd_drive && fall) begin
            if (!st_ff.rd_half) begin
                nxt_st.rd_half = 1'b1;
                nxt_st.dq_out = ~i_rd_data;
                nxt_st.dqs_out = '0; // R2 R15
            end
        end else if (st_ff.rd_drive && rise) begin
            nxt_st.rd_drive = 1'b0;
        end
        if (!awake) begin
            nxt_st.rd_drive = 1'b0; // R3
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_srst) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    beat_buffer #(.W(BW)) u_beat_buffer (
        .i_ref_clk(i_ref_clk),
        .i_srst(i_srst),
        .i_valid(st_ff.push),
        .o_ready(buf_ready),
        .i_data({st_ff.wr_data, st_ff.wr_keep}),
        .o_valid(o_wr_valid),
        .i_ready(i_wr_ready),
        .o_data(buf_out)
    );

    assign {o_wr_data, o_wr_keep} = buf_out;
    assign o_wr_bank = st_ff.wr_bank;
    assign o_wr_col = st_ff.wr_col;
    assign o_rd_bank = st_ff.rd_bank;
    assign o_rd_col = st_ff.rd_col;
    assign o_rd_req = (st_ff.rd_cnt != 2'h0);
    assign o_dq = st_ff.dq_out;
    assign o_dq_oe = st_ff.rd_drive; // R17
    assign o_byte_strobe = st_ff.dqs_out;
    assign o_byte_strobe_oe = st_ff.rd_drive;
    assign o_overtemp_flag = st_ff.ot; // R16
    assign o_bank_open = st_ff.open;
    assign o_power_state = st_ff.pwr;
    assign o_mode_reg0 = st_ff.mode[0];
    assign o_mode_reg1 = st_ff.mode[1];
    assign o_cmd_ignored = st_ff.ignored;

    property p_cs_masks;
        @(posedge i_ref_clk) disable iff (i_srst)
        (rise && awake && s_gate && s_cs_n) |=> (o_bank_open == $past(o_bank_open));
    endproperty
    a_cs_masks: assert property (p_cs_masks) else $error("masked command acted"); // R7

    property p_act_opens;
        @(posedge i_ref_clk) disable iff (i_srst)
        (rise && awake && s_gate && !s_cs_n && cmd == CMD_ACT) |=> o_bank_open[$past(s_ba)];
    endproperty
    a_act_opens: assert property (p_act_opens) else $error("activate missed bank"); // R10

    property p_pre_all;
        @(posedge i_ref_clk) disable iff (i_srst)
        (rise && awake && s_gate && !s_cs_n && cmd == CMD_PRE && s_addr[AP_BIT])
        |=> (o_bank_open == '0);
    endproperty
    a_pre_all: assert property (p_pre_all) else $error("precharge all failed"); // R13

    property p_lmr;
        @(posedge i_ref_clk) disable iff (i_srst)
        (rise && awake && s_gate && !s_cs_n && cmd == CMD_LMR && s_ba == 2'h0)
        |=> (o_mode_reg0 == $past(s_addr));
    endproperty
    a_lmr: assert property (p_lmr) else $error("mode load wrong"); // R11

    property p_pd_no_drive;
        @(posedge i_ref_clk) disable iff (i_srst)
        (o_power_state != PWR_ACTIVE) |=> !o_dq_oe;
    endproperty
    a_pd_no_drive: assert property (p_pd_no_drive) else $error("drives in power-down"); // R3

    property p_sr_exit;
        @(posedge i_ref_clk) disable iff (i_srst)
        (o_power_state == PWR_SELF_REF && s_gate) |=> (o_power_state == PWR_ACTIVE);
    endproperty
    a_sr_exit: assert property (p_sr_exit) else $error("self refresh exit late"); // R5

    property p_act_pd;
        @(posedge i_ref_clk) disable iff (i_srst)
        (rise && awake && !s_gate && o_bank_open != '0) |=> (o_power_state == PWR_ACT_PD);
    endproperty
    a_act_pd: assert property (p_act_pd) else $error("active power-down missed"); // R4

    property p_ot;
        @(posedge i_ref_clk) disable iff (i_srst)
        i_over_threshold [*4] |-> o_overtemp_flag;
    endproperty
    a_ot: assert property (p_ot) else $error("overtemp flag low"); // R16

    property p_ot_low;
        @(posedge i_ref_clk) disable iff (i_srst)
        (!i_over_threshold) [*4] |-> !o_overtemp_flag;
    endproperty
    a_ot_low: assert property (p_ot_low) else $error("overtemp flag high"); // R16

    property p_ignored_pulse;
        @(posedge i_ref_clk) disable iff (i_srst)
        (rise && awake && s_gate && s_cs_n) |=> o_cmd_ignored;
    endproperty
    a_ignored_pulse: assert property (p_ignored_pulse) else $error("no ignore pulse"); // R7

    property p_no_loss;
        @(posedge i_ref_clk) disable iff (i_srst)
        st_ff.push |-> buf_ready;
    endproperty
    a_no_loss: assert property (p_no_loss) else $error("write beat dropped"); // R9

    property p_wr_keep;
        @(posedge i_ref_clk) disable iff (i_srst)
        st_ff.push |-> (st_ff.wr_keep == ~$past(s_dm));
    endproperty
    a_wr_keep: assert property (p_wr_keep) else $error("write keep wrong"); // R9
endmodule : lpddr_pin_device

// file: host_ctrl_model.sv
// Purpose: host controller model driving link clock, commands and write data
// Assumes: link clock of 800 ns that can be halted low on request
// Notes: released data lines toggle on every link edge
module host_ctrl_model
    import lpddr_pin_pkg::*;
(
    input wire logic i_halt,
    output logic o_link_clk,
    output cmd_bus_t o_cmd,
    output beat_t o_beat,
    output logic o_dq_oe,
    output logic [LANES-1:0] o_strobe
);
    timeunit 1ns;
    timeprecision 1ns;
    localparam cmd_bus_t IDLE = {1'h0, CMD_NOP, 2'h0, 14'h0};

    initial begin
        o_link_clk = 1'h0;
        o_cmd = IDLE;
        o_beat = '0;
        o_dq_oe = 1'h0;
        o_strobe = '0;
        #25;
        forever begin
            #400;
            // clock stands low while halted
            if (!i_halt || o_link_clk)
                o_link_clk = ~o_link_clk;
        end
    end

    always @(o_link_clk) begin
        if (!o_dq_oe)
            o_beat.data = ~o_beat.data;
        // strobe stands still outside write bursts, mid-eye inside them
        #200;
        if (o_dq_oe)
            o_strobe = ~o_strobe;
    end

    task automatic send(input cmd_bus_t c, input beat_t b);
        @(negedge o_link_clk);
        o_cmd = c;
        @(posedge o_link_clk);
        if ({c.ras_n, c.cas_n, c.we_n} == CMD_WR && !c.command_select_die0_n) begin
            o_beat = b;
            o_dq_oe = 1'h1;
        end
        @(negedge o_link_clk);
        o_cmd = IDLE;
        @(posedge o_link_clk);
        o_dq_oe = 1'h0;
    endtask : send
endmodule : host_ctrl_model

// file: test_lpddr_pin_device.sv
// Purpose: self-checking bench for the device-side pin interface
// Assumes: 10 MHz reference clock, link clock from the host model
// Notes: table rows cover mode, activate and precharge; awkward cases follow
module test_lpddr_pin_device import lpddr_pin_pkg::*;;
    timeunit 1ns;
    timeprecision 1ns;
    typedef struct packed {
        cmd_bus_t c;
        logic [3:0] open;
        logic [13:0] mr0;
        logic [13:0] mr1;
    } row_t;
    logic i_ref_clk, i_srst, halt, gate, thr, wr_ready, host_oe, link_clk;
    logic ignored, flag, dq_oe, strobe_oe, wr_valid, rd_req;
    cmd_bus_t cmd;
    beat_t beat;
    logic [1:0] hstrobe, o_strobe, keep, wr_bank, rd_bank, pstate;
    logic [15:0] dq, o_dq, wr_data, rd_data;
    logic [13:0] wr_col, rd_col, mr0, mr1;
    logic [3:0] open;
    int err_count = 0;
    int samples_checked = 0;
    int ign_cnt = 0;
    row_t rows[10];

    assign dq = (host_oe || !dq_oe) ? beat.data : o_dq;

    host_ctrl_model model (.i_halt(halt), .o_link_clk(link_clk), .o_cmd(cmd),
        .o_beat(beat), .o_dq_oe(host_oe), .o_strobe(hstrobe));

    // die1 inputs tied: single-die part
    lpddr_pin_device lpddr_pin_device_inst (.i_ref_clk(i_ref_clk), .i_srst(i_srst),
        .i_link_clk(link_clk), .i_power_gate_die0(gate), .i_power_gate_die1(1'h0),
        .i_command_select_die0_n(cmd.command_select_die0_n),
        .i_command_select_die1_n(1'h1), .i_ras_n(cmd.ras_n), .i_cas_n(cmd.cas_n),
        .i_we_n(cmd.we_n), .i_bank_select_0(cmd.bank_select_0),
        .i_bank_select_1(cmd.bank_select_1), .i_addr(cmd.addr),
        .i_write_byte_mask(beat.write_byte_mask), .i_dq(dq), .o_dq(o_dq),
        .o_dq_oe(dq_oe), .i_byte_strobe(hstrobe), .o_byte_strobe(o_strobe),
        .o_byte_strobe_oe(strobe_oe), .i_over_threshold(thr), .o_overtemp_flag(flag),
        .o_bank_open(open), .o_power_state(pstate), .o_wr_valid(wr_valid),
        .i_wr_ready(wr_ready), .o_wr_data(wr_data), .o_wr_keep(keep),
        .o_wr_bank(wr_bank), .o_wr_col(wr_col), .i_rd_data(rd_data),
        .o_rd_bank(rd_bank), .o_rd_col(rd_col), .o_rd_req(rd_req),
        .o_mode_reg0(mr0), .o_mode_reg1(mr1), .o_cmd_ignored(ignored));

    initial begin
        i_ref_clk = 1'h0;
        forever #50 i_ref_clk = ~i_ref_clk;
    end

    always @(posedge i_ref_clk) begin
        if (ignored === 1'h1)
            ign_cnt++;
    end

    task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
        samples_checked++;
        if (got !== exp) begin
            $display("FAIL %s expected %h seen %h", nm, exp, got);
            err_count++;
        end
    endtask : chk

    task automatic wait_ref(input int n);
        repeat (n) @(negedge i_ref_clk);
    endtask : wait_ref

    function automatic cmd_bus_t mk(input logic s, input logic [2:0] op,
        input logic [1:0] ba, input logic [13:0] a);
        return {s, op, ba, a};
    endfunction : mk

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : wrap_up

    initial begin
        #2000000;
        err_count++;
        wrap_up();
    end

    initial begin
        int n;
        i_srst = 1'h1;
        halt = 1'h0;
        gate = 1'h1;
        thr = 1'h0;
        wr_ready = 1'h1;
        rd_data = 16'h5aa5;
        rows[0] = '{mk(1'h0, CMD_LMR, 2'h0, 14'h0123), 4'h0, 14'h0123, 14'h0};
        rows[1] = '{mk(1'h0, CMD_LMR, 2'h1, 14'h0456), 4'h0, 14'h0123, 14'h0456};
        rows[2] = '{mk(1'h0, CMD_LMR, 2'h2, 14'h3fff), 4'h0, 14'h0123, 14'h0456};
        rows[3] = '{mk(1'h0, CMD_ACT, 2'h2, 14'h1abc), 4'h4, 14'h0123, 14'h0456};
        rows[4] = '{mk(1'h0, CMD_ACT, 2'h1, 14'h0001), 4'h6, 14'h0123, 14'h0456};
        rows[5] = '{mk(1'h0, CMD_PRE, 2'h2, 14'h0000), 4'h2, 14'h0123, 14'h0456};
        rows[6] = '{mk(1'h1, CMD_ACT, 2'h0, 14'h0000), 4'h2, 14'h0123, 14'h0456};
        rows[7] = '{mk(1'h0, CMD_ACT, 2'h3, 14'h0002), 4'ha, 14'h0123, 14'h0456};
        rows[8] = '{mk(1'h0, CMD_PRE, 2'h0, 14'h0400), 4'h0, 14'h0123, 14'h0456};
        rows[9] = '{mk(1'h0, CMD_ACT, 2'h1, 14'h0003), 4'h2, 14'h0123, 14'h0456};
        wait_ref(5);
        i_srst = 1'h0;
        wait_ref(4);
        foreach (rows[i]) begin
            model.send(rows[i].c, '0);
            wait_ref(4);
            chk("bank_open", 16'(rows[i].open), 16'(open));
            chk("mode_reg0", 16'(rows[i].mr0), 16'(mr0));
            chk("mode_reg1", 16'(rows[i].mr1), 16'(mr1));
        end
        chk("ignored", 16'h1, 16'(ign_cnt));
        $display("table test done");
        model.send(mk(1'h0, CMD_RD, 2'h1, 14'h0005), '0);
        chk("rd_req", 16'h1, 16'(rd_req));
        n = 0;
        while (dq_oe !== 1'h1 && n < 100) begin
            wait_ref(1);
            n++;
        end
        chk("rd_bank", 16'h1, 16'(rd_bank));
        chk("rd_col", 16'h5, 16'(rd_col));
        chk("rd_dq", 16'h5aa5, o_dq);
        chk("rd_strobe_oe", 16'h1, 16'(strobe_oe));
        chk("rd_strobe", 16'h3, 16'(o_strobe));
        wait_ref(4);
        chk("rd_dq2", 16'ha55a, o_dq);
        chk("rd_strobe2", 16'h0, 16'(o_strobe));
        chk("rd_req_done", 16'h0, 16'(rd_req));
        $display("read test done");
        wr_ready = 1'h0;
        model.send(mk(1'h0, CMD_WR, 2'h3, 14'h0010), '{16'hbeef, 2'h2});
        wait_ref(20);
        chk("wr_valid_stall", 16'h1, 16'(wr_valid));
        wr_ready = 1'h1;
        repeat (2) begin
            n = 0;
            while (wr_valid !== 1'h1 && n < 50) begin
                wait_ref(1);
                n++;
            end
            chk("wr_low_byte", 16'h00ef, 16'(wr_data[7:0]));
            chk("wr_keep", 16'h1, 16'(keep));
            wait_ref(1);
        end
        chk("wr_drained", 16'h0, 16'(wr_valid));
        chk("wr_bank", 16'h3, 16'(wr_bank));
        chk("wr_col", 16'h10, 16'(wr_col));
        $display("write test done");
        gate = 1'h0;
        wait_ref(12);
        chk("act_pd", 16'(PWR_ACT_PD), 16'(pstate));
        model.send(mk(1'h0, CMD_ACT, 2'h2, 14'h0000), '0);
        wait_ref(4);
        chk("pd_ignores", 16'h2, 16'(open));
        gate = 1'h1;
        wait_ref(12);
        chk("pd_exit", 16'(PWR_ACTIVE), 16'(pstate));
        model.send(mk(1'h0, CMD_PRE, 2'h0, 14'h0400), '0);
        wait_ref(4);
        chk("pre_all", 16'h0, 16'(open));
        gate = 1'h0;
        wait_ref(12);
        chk("pre_pd", 16'(PWR_PRE_PD), 16'(pstate));
        gate = 1'h1;
        wait_ref(12);
        fork
            model.send(mk(1'h0, CMD_REF, 2'h0, 14'h0000), '0);
            begin
                @(negedge link_clk);
                wait_ref(1);
                gate = 1'h0;
            end
        join
        wait_ref(8);
        chk("self_ref", 16'(PWR_SELF_REF), 16'(pstate));
        halt = 1'h1;
        wait_ref(20);
        gate = 1'h1;
        wait_ref(10);
        chk("sr_exit_async", 16'(PWR_ACTIVE), 16'(pstate));
        halt = 1'h0;
        wait_ref(12);
        $display("power test done");
        thr = 1'h1;
        wait_ref(4);
        chk("overtemp_hi", 16'h1, 16'(flag));
        thr = 1'h0;
        wait_ref(4);
        chk("overtemp_lo", 16'h0, 16'(flag));
        $display("overtemp test done");
        model.send(mk(1'h0, CMD_ACT, 2'h0, 14'h0007), '0);
        wait_ref(4);
        chk("act_before_rst", 16'h1, 16'(open));
        i_srst = 1'h1;
        wait_ref(2);
        chk("rst_open", 16'h0, 16'(open));
        chk("rst_mode0", 16'h0, 16'(mr0));
        chk("rst_state", 16'h0, 16'(pstate));
        i_srst = 1'h0;
        wait_ref(4);
        chk("rst_release_open", 16'h0, 16'(open));
        $display("reset test done");
        wrap_up();
    end
endmodule : test_lpddr_pin_device
